/* i2c_master_model.sv */
// i2c bus master model driving clock and data
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    // clock and wired data level
    input wire logic clk_sys_i,
    input wire logic sda_i,
    // master drives, high releases
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : wait_n

    // start or repeated start
    task automatic start_c();
        sda_o <= 1'b1;
        wait_n(4);
        scl_o <= 1'b1;
        wait_n(8);
        sda_o <= 1'b0;
        wait_n(8);
        scl_o <= 1'b0;
        wait_n(2);
    endtask : start_c

    task automatic stop_c();
        sda_o <= 1'b0;
        wait_n(6);
        scl_o <= 1'b1;
        wait_n(8);
        sda_o <= 1'b1;
        wait_n(8);
    endtask : stop_c

    // one clock: data set in low phase, sampled in high phase
    task automatic bit_x(input logic b, output logic r);
        sda_o <= b;
        wait_n(6);
        scl_o <= 1'b1;
        wait_n(8);
        r = sda_i;
        scl_o <= 1'b0;
        wait_n(2);
    endtask : bit_x

    // msb first byte, ninth bit is ack slot
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(last, ack);
    endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

/* rtc_pkg.sv */
// shared constants and carrier types for the serial clock/calendar
package rtc_pkg;

    // register space
    localparam logic [5:0] ADDR_FIRST = 6'h00;
    localparam logic [5:0] ADDR_LAST = 6'h3f;
    localparam logic [5:0] RAM_FIRST = 6'h08;
    localparam int RAM_DEPTH = 56;

    // clock bank indices
    localparam logic [2:0] IDX_SEC = 3'h0;
    localparam logic [2:0] IDX_MIN = 3'h1;
    localparam logic [2:0] IDX_HOUR = 3'h2;
    localparam logic [2:0] IDX_DOW = 3'h3;
    localparam logic [2:0] IDX_DATE = 3'h4;
    localparam logic [2:0] IDX_MONTH = 3'h5;
    localparam logic [2:0] IDX_YEAR = 3'h6;
    localparam logic [2:0] IDX_CTRL = 3'h7;

    // field positions
    localparam int CH_BIT = 7;
    localparam int H12_BIT = 6;
    localparam int PM_BIT = 5;
    localparam int OUT_BIT = 7;
    localparam int SQUARE_WAVE_ENABLE_BIT = 4;
    localparam int RS_HI = 1;
    localparam int RS_LO = 0;

    // square wave rate selections
    localparam logic [1:0] RS_1HZ = 2'h0;
    localparam logic [1:0] RS_4K = 2'h1;
    localparam logic [1:0] RS_8K = 2'h2;
    localparam logic [1:0] RS_32K = 2'h3;

    // sub-second divider, one count per oscillator cycle
    localparam int DIV_W = 15;
    localparam logic [DIV_W-1:0] DIV_LAST = 15'h7fff;
    localparam int DIV_TAP_1HZ = 14;
    localparam int DIV_TAP_4K = 2;
    localparam int DIV_TAP_8K = 1;

    // bcd limits
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] BCD_07 = 8'h07;
    localparam logic [7:0] BCD_11 = 8'h11;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] BCD_00 = 8'h00;

    typedef logic [7:0][7:0] time_bank_t;

    // power-on contents and writable bits of the clock bank
    localparam time_bank_t BANK_RST = {8'h03, 8'h00, 8'h01, 8'h01,
                                       8'h01, 8'h00, 8'h00, 8'h80};
    localparam time_bank_t WR_MASK = {8'h93, 8'hff, 8'h1f, 8'h3f,
                                      8'h07, 8'h7f, 8'h7f, 8'hff};

    // serial byte framing
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // synchronised pin indices
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_OSC = 2;
    localparam int PIN_PF = 3;
    localparam int PIN_LOW = 4;
    localparam int PIN_HIGH = 5;
    localparam int PIN_W = 6;

    typedef struct packed {
        logic en;
        logic [2:0] idx;
        logic [7:0] data;
    } tk_wr_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV = 4'h1,
        ST_DEV_ACK = 4'h3,
        ST_PTR = 4'h2,
        ST_PTR_ACK = 4'h6,
        ST_WR = 4'h7,
        ST_WR_ACK = 4'h5,
        ST_RD = 4'h4,
        ST_RD_ACK = 4'hc
    } bus_state_t;

endpackage : rtc_pkg

/* rtc_serial_core.sv */
// serial clock/calendar: i2c slave, ram, supply gating, square wave
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_core #(
    parameter logic [6:0] SLAVE_ADDR = 7'h2a // arbitrary value
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // i2c pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // oscillator
    input wire logic crystal_input_i,
    // supply comparators
    input wire logic power_fail_i,
    input wire logic vcc_below_bat_i,
    input wire logic vcc_above_bat_margin_i,
    // status
    output logic backup_mode_o,
    output logic bus_blocked_o,
    // square wave pin
    output logic square_wave_output_pin_o,
    output logic square_wave_output_pin_oe_o
);
    import rtc_pkg::*;

    // pin synchronisers
    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;
    logic [PIN_W-1:0] prev_r;

    wire [PIN_W-1:0] pins = {vcc_above_bat_margin_i, vcc_below_bat_i,
                             power_fail_i, crystal_input_i, sda_i, scl_i};

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else if (clk_en_i) begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // edge and condition decode
    wire scl_s = sync2_r[PIN_SCL];
    wire sda_s = sync2_r[PIN_SDA];
    wire scl_d = prev_r[PIN_SCL];
    wire sda_d = prev_r[PIN_SDA];
    wire pf = sync2_r[PIN_PF];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_ev = scl_s & scl_d & ~sda_d & sda_s;
    wire osc_tick = sync2_r[PIN_OSC] & ~prev_r[PIN_OSC];

    // bus state
    bus_state_t st_r;
    bus_state_t st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [5:0] ptr_r;
    logic [5:0] ptr_nxt;
    logic oe_r;
    logic oe_nxt;
    logic rw_r;
    logic rw_nxt;
    logic nack_r;
    logic nack_nxt;
    logic bk_r;
    logic bk_nxt;
    logic sqw_r;
    logic sqw_nxt;

    // storage
    time_bank_t bank;
    time_bank_t shadow_r;
    logic [DIV_W-1:0] div;
    logic [7:0] ram_r [RAM_DEPTH];
    tk_wr_t tk_wr;

    // access decode
    wire live = ~pf & ~start_ev & ~stop_ev;
    wire rx_state = (st_r == ST_DEV) | (st_r == ST_PTR) | (st_r == ST_WR);
    wire byte_done = scl_fall & (cnt_r == BITS_BYTE);
    wire addr_hit = (sh_r[7:1] == SLAVE_ADDR);
    wire is_clk = (ptr_r < RAM_FIRST);
    wire [5:0] ram_idx = ptr_r - RAM_FIRST;
    wire [5:0] ptr_inc = (ptr_r == ADDR_LAST) ? ADDR_FIRST
                                              : ptr_r + 6'h01;
    wire [7:0] rd_byte = is_clk ? shadow_r[ptr_r[2:0]] : ram_r[ram_idx];
    wire wr_commit = live & (st_r == ST_WR) & byte_done;
    wire rd_load = live & scl_fall &
                   (((st_r == ST_DEV_ACK) & rw_r) | ((st_r == ST_RD_ACK) & ~nack_r));

    assign tk_wr.en = wr_commit & is_clk;
    assign tk_wr.idx = ptr_r[2:0];
    assign tk_wr.data = sh_r;

    rtc_timekeeper u_timekeeper (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .osc_tick_i(osc_tick),
        .wr_i(tk_wr),
        .bank_o(bank),
        .div_o(div)
    );

    // i2c slave sequencing
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        oe_nxt = oe_r;
        rw_nxt = rw_r;
        nack_nxt = nack_r;
        if (pf) begin
            st_nxt = ST_IDLE;
            ptr_nxt = ADDR_FIRST;
            oe_nxt = 1'b0;
        end else if (start_ev) begin
            st_nxt = ST_DEV;
            cnt_nxt = '0;
            oe_nxt = 1'b0;
        end else if (stop_ev) begin
            st_nxt = ST_IDLE;
            oe_nxt = 1'b0;
        end else begin
            if (rx_state && scl_rise) begin
                sh_nxt = {sh_r[6:0], sda_s};
                cnt_nxt = cnt_r + 4'h1;
            end
            case (st_r)
                ST_DEV: begin
                    if (byte_done) begin
                        cnt_nxt = '0;
                        if (addr_hit) begin
                            st_nxt = ST_DEV_ACK;
                            oe_nxt = 1'b1;
                            rw_nxt = sh_r[0];
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                end
                ST_DEV_ACK: begin
                    if (scl_fall) begin
                        st_nxt = rw_r ? ST_RD : ST_PTR;
                        oe_nxt = 1'b0;
                    end
                end
                ST_PTR: begin
                    if (byte_done) begin
                        st_nxt = ST_PTR_ACK;
                        cnt_nxt = '0;
                        oe_nxt = 1'b1;
                        ptr_nxt = sh_r[5:0];
                    end
                end
                ST_PTR_ACK: begin
                    if (scl_fall) begin
                        st_nxt = ST_WR;
                        oe_nxt = 1'b0;
                    end
                end
                ST_WR: begin
                    if (byte_done) begin
                        st_nxt = ST_WR_ACK;
                        cnt_nxt = '0;
                        oe_nxt = 1'b1;
                        ptr_nxt = ptr_inc;
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        st_nxt = ST_WR;
                        oe_nxt = 1'b0;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (cnt_r == LAST_BIT) begin
                            st_nxt = ST_RD_ACK;
                            cnt_nxt = '0;
                            oe_nxt = 1'b0;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            cnt_nxt = cnt_r + 4'h1;
                            oe_nxt = ~sh_r[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        nack_nxt = sda_s;
                    end
                    if (scl_fall && nack_r) begin
                        st_nxt = ST_IDLE;
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                end
            endcase
            if (rd_load) begin
                st_nxt = ST_RD;
                cnt_nxt = '0;
                sh_nxt = rd_byte;
                oe_nxt = ~rd_byte[7];
                ptr_nxt = ptr_inc;
            end
        end
    end

    // backup supply hysteresis
    assign bk_nxt = sync2_r[PIN_LOW] ? 1'b1 :
                    sync2_r[PIN_HIGH] ? 1'b0 : bk_r;

    // square wave source
    wire [7:0] ctrl = bank[IDX_CTRL];
    wire [1:0] rs = ctrl[RS_HI:RS_LO];
    wire rate_bit = (rs == RS_1HZ) ? div[DIV_TAP_1HZ] :
                    (rs == RS_4K) ? div[DIV_TAP_4K] :
                    (rs == RS_8K) ? div[DIV_TAP_8K] : sync2_r[PIN_OSC];
    assign sqw_nxt = ctrl[SQUARE_WAVE_ENABLE_BIT] ? rate_bit : ctrl[OUT_BIT];

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
            sh_r <= '0;
            ptr_r <= ADDR_FIRST;
            oe_r <= 1'b0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            oe_r <= oe_nxt;
            rw_r <= rw_nxt;
            nack_r <= nack_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shadow_r <= BANK_RST;
            bk_r <= 1'b0;
            sqw_r <= 1'b0;
        end else if (clk_en_i) begin
            if (start_ev && !pf) begin
                shadow_r <= bank;
            end
            bk_r <= bk_nxt;
            sqw_r <= sqw_nxt;
        end
    end

    // general purpose ram
    always_ff @(posedge clk_sys_i) begin
        if (clk_en_i && wr_commit && !is_clk) begin
            ram_r[ram_idx] <= sh_r;
        end
    end

    // open drain sda and square wave outputs, driven low when enabled; status outputs driven directly
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_r;
    assign square_wave_output_pin_o = 1'b0;
    assign square_wave_output_pin_oe_o = ~sqw_r;
    assign backup_mode_o = bk_r;
    assign bus_blocked_o = pf;

endmodule : rtc_serial_core
`default_nettype wire

/* rtc_serial_core_monitor.sv */
// pin-level checks for the serial clock/calendar
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_core_monitor (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // i2c pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // oscillator and supply
    input wire logic crystal_input_i,
    input wire logic power_fail_i,
    input wire logic vcc_below_bat_i,
    input wire logic vcc_above_bat_margin_i,
    // status and square wave
    input wire logic backup_mode_o,
    input wire logic bus_blocked_o,
    input wire logic square_wave_output_pin_o,
    input wire logic square_wave_output_pin_oe_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_fail_held;
        power_fail_i [*3];
    endsequence
    sequence s_supply_good;
        !power_fail_i [*3];
    endsequence
    sequence s_below_held;
        vcc_below_bat_i [*6];
    endsequence
    sequence s_above_held;
        (vcc_above_bat_margin_i && !vcc_below_bat_i) [*6];
    endsequence

    chk_fail_blocks: assert property (s_fail_held |-> ##[0:2] bus_blocked_o)
        else $error("bus not blocked on power fail");
    chk_supply_opens: assert property (s_supply_good |-> ##[0:2] !bus_blocked_o)
        else $error("bus still blocked with good supply");
    chk_blocked_quiet: assert property (bus_blocked_o [*3] |-> !sda_oe_o)
        else $error("data line driven while blocked");
    chk_backup_enter: assert property (s_below_held |-> backup_mode_o)
        else $error("backup mode not entered");
    chk_backup_leave: assert property (s_above_held |-> !backup_mode_o)
        else $error("backup mode not left");
    chk_drive_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive changed while clock high");
    chk_ack_holds: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
        else $error("data drive too short");
    chk_refused_ack: assert property ($rose(sda_oe_o) |->
        !$past(bus_blocked_o) && !sda_o && !square_wave_output_pin_o)
        else $error("data line driven on a blocked bus");
endmodule : rtc_serial_core_monitor

bind rtc_serial_core rtc_serial_core_monitor rtc_serial_core_monitor_i (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .crystal_input_i(crystal_input_i), .power_fail_i(power_fail_i),
    .vcc_below_bat_i(vcc_below_bat_i), .vcc_above_bat_margin_i(vcc_above_bat_margin_i),
    .backup_mode_o(backup_mode_o), .bus_blocked_o(bus_blocked_o),
    .square_wave_output_pin_o(square_wave_output_pin_o),
    .square_wave_output_pin_oe_o(square_wave_output_pin_oe_o)
);
`default_nettype wire

/* rtc_timekeeper.sv */
// clock/calendar counters and sub-second divider
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeper (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // oscillator tick and write port
    input wire logic osc_tick_i,
    input wire rtc_pkg::tk_wr_t wr_i,
    // state
    output rtc_pkg::time_bank_t bank_o,
    output logic [rtc_pkg::DIV_W-1:0] div_o
);
    import rtc_pkg::*;

    time_bank_t bank_r;
    time_bank_t bank_nxt;
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_nxt;

    function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
        if (v >= hi) begin
            return lo;
        end else if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return v + 8'h01;
    endfunction : bcd_next

    function automatic logic [7:0] month_len(input logic [7:0] m,
                                             input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == 8'h02) begin
            return leap ? 8'h29 : 8'h28;
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
            return 8'h30;
        end
        return 8'h31;
    endfunction : month_len

    wire halted = bank_r[IDX_SEC][CH_BIT];
    wire sec_tick = osc_tick_i & ~halted & (div_r == DIV_LAST);
    wire [7:0] sec_v = {1'b0, bank_r[IDX_SEC][6:0]};
    wire [7:0] sec_n = bcd_next(sec_v, BCD_00, BCD_59);
    wire [7:0] min_n = bcd_next(bank_r[IDX_MIN], BCD_00, BCD_59);
    wire [7:0] hour_v = bank_r[IDX_HOUR];
    wire h12 = hour_v[H12_BIT];
    wire pm = hour_v[PM_BIT];
    wire [7:0] hr12 = {3'h0, hour_v[4:0]};
    wire [7:0] hr24 = {2'h0, hour_v[5:0]};
    wire [7:0] hr12_n = bcd_next(hr12, BCD_01, BCD_12);
    wire [7:0] hr24_n = bcd_next(hr24, BCD_00, BCD_23);
    wire [7:0] hour_n = h12 ? {2'b01, pm ^ (hr12 == BCD_11), hr12_n[4:0]}
                            : {2'b00, hr24_n[5:0]};
    wire hour_wrap = h12 ? (hr12 == BCD_11 && pm) : (hr24 == BCD_23);
    wire [7:0] mlen = month_len(bank_r[IDX_MONTH], bank_r[IDX_YEAR]);
    wire [7:0] date_n = bcd_next(bank_r[IDX_DATE], BCD_01, mlen);
    wire [7:0] dow_n = bcd_next(bank_r[IDX_DOW], BCD_01, BCD_07);
    wire [7:0] month_n = bcd_next(bank_r[IDX_MONTH], BCD_01, BCD_12);
    wire [7:0] year_n = bcd_next(bank_r[IDX_YEAR], BCD_00, BCD_99);

    always_comb begin
        bank_nxt = bank_r;
        div_nxt = div_r;
        if (osc_tick_i && !halted) begin
            div_nxt = div_r + 15'h0001;
        end
        if (sec_tick) begin
            bank_nxt[IDX_SEC] = {halted, sec_n[6:0]};
            if (sec_v == BCD_59) begin
                bank_nxt[IDX_MIN] = min_n;
                if (bank_r[IDX_MIN] == BCD_59) begin
                    bank_nxt[IDX_HOUR] = hour_n;
                    if (hour_wrap) begin
                        bank_nxt[IDX_DOW] = dow_n;
                        bank_nxt[IDX_DATE] = date_n;
                        if (bank_r[IDX_DATE] >= mlen) begin
                            bank_nxt[IDX_MONTH] = month_n;
                            if (bank_r[IDX_MONTH] == BCD_12) begin
                                bank_nxt[IDX_YEAR] = year_n;
                            end
                        end
                    end
                end
            end
        end
        if (wr_i.en) begin
            bank_nxt[wr_i.idx] = wr_i.data & WR_MASK[wr_i.idx];
            if (wr_i.idx == IDX_SEC) begin
                div_nxt = '0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bank_r <= BANK_RST;
            div_r <= '0;
        end else if (clk_en_i) begin
            bank_r <= bank_nxt;
            div_r <= div_nxt;
        end
    end

    assign bank_o = bank_r;
    assign div_o = div_r;

endmodule : rtc_timekeeper
`default_nettype wire

/* tb_top.sv */
// testbench for the serial clock/calendar
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rtc_pkg::*;
    localparam logic [6:0] DEV = 7'h2a;
    localparam logic [7:0] RATE [4] = '{8'h00, 8'h08, 8'h10, 8'h40};
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic osc = 1'b0;
    logic pf = 1'b0;
    logic below = 1'b0;
    logic above = 1'b1;
    logic scl_m;
    logic sda_m;
    logic sda_oe;
    logic sq_oe;
    logic backup;
    logic blocked;
    wire logic sda_w = sda_m & ~sda_oe;
    logic [7:0] rd [$];
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        osc <= ~osc;
        cycles <= cycles + 1;
    end

    rtc_serial_core #(.SLAVE_ADDR(DEV)) rtc_serial_core_i (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .scl_i(scl_m), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
        .crystal_input_i(osc), .power_fail_i(pf), .vcc_below_bat_i(below),
        .vcc_above_bat_margin_i(above), .backup_mode_o(backup), .bus_blocked_o(blocked),
        .square_wave_output_pin_o(), .square_wave_output_pin_oe_o(sq_oe)
    );
    i2c_master_model i2c_master_model_i (
        .clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    always @(posedge clk_sys_i) begin
        if (cycles == 90000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", w, e, s);
        end
    endtask : check

    task automatic chk1(input string w, input logic s, input logic e);
        check(w, {7'h0, s}, {7'h0, e});
    endtask : chk1

    task automatic same(input logic [7:0] e [$]);
        foreach (e[i]) begin
            check("read", rd[i], e[i]);
        end
    endtask : same

    task automatic open_at(input logic [5:0] a);
        logic [7:0] r;
        logic nak;
        i2c_master_model_i.start_c();
        i2c_master_model_i.xfer({DEV, 1'b0}, 1'b1, r, nak);
        chk1("dev ack", nak, 1'b0);
        i2c_master_model_i.xfer({2'h0, a}, 1'b1, r, nak);
        chk1("ptr ack", nak, 1'b0);
    endtask : open_at

    task automatic put(input logic [5:0] a, input logic [7:0] d [$]);
        logic [7:0] r;
        logic nak;
        open_at(a);
        foreach (d[i]) begin
            i2c_master_model_i.xfer(d[i], 1'b1, r, nak);
            chk1("data ack", nak, 1'b0);
        end
        i2c_master_model_i.stop_c();
    endtask : put

    task automatic get(input logic [5:0] a, input int n, input logic set);
        logic [7:0] r;
        logic nak;
        if (set) begin
            open_at(a);
        end
        i2c_master_model_i.start_c();
        i2c_master_model_i.xfer({DEV, 1'b1}, 1'b1, r, nak);
        chk1("rd ack", nak, 1'b0);
        rd.delete();
        for (int i = 0; i < n; i++) begin
            i2c_master_model_i.xfer(8'hff, i == n - 1, r, nak);
            rd.push_back(r);
        end
        i2c_master_model_i.stop_c();
    endtask : get

    task automatic s_reset();
        chk1("backup", backup, 1'b0);
        chk1("blocked", blocked, 1'b0);
        chk1("sq oe", sq_oe, 1'b1);
        chk1("sda oe", sda_oe, 1'b0);
    endtask : s_reset

    task automatic s_burst();
        put(6'h08, '{8'h11, 8'h22, 8'h33});
        get(6'h08, 3, 1'b1);
        same('{8'h11, 8'h22, 8'h33});
    endtask : s_burst

    task automatic s_wrap();
        logic [7:0] r;
        logic nak;
        put(6'h3f, '{8'h5c, 8'h00});
        get(6'h3f, 2, 1'b1);
        same('{8'h5c, 8'h00});
        i2c_master_model_i.start_c();
        i2c_master_model_i.xfer({DEV ^ 7'h01, 1'b0}, 1'b1, r, nak);
        chk1("foreign", nak, 1'b1);
        i2c_master_model_i.stop_c();
    endtask : s_wrap

    task automatic s_square();
        int n;
        logic prev;
        below <= 1'b1;
        above <= 1'b0;
        for (int rs = 0; rs < 4; rs++) begin
            put(6'h07, '{8'h10 | 8'(rs)});
            repeat (8) @(posedge clk_sys_i);
            n = 0;
            prev = sq_oe;
            repeat (64) begin
                @(posedge clk_sys_i);
                n += int'(sq_oe != prev);
                prev = sq_oe;
            end
            check("rate", 8'(n), RATE[rs]);
        end
        chk1("backup on", backup, 1'b1);
        below <= 1'b0;
        above <= 1'b1;
        put(6'h07, '{8'h80});
        chk1("out high", sq_oe, 1'b0);
        put(6'h07, '{8'h00});
        chk1("out low", sq_oe, 1'b1);
        chk1("backup off", backup, 1'b0);
    endtask : s_square

    task automatic s_power();
        logic [7:0] r;
        logic nak;
        put(6'h00, '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h01});
        open_at(6'h08);
        pf <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        chk1("blocked", blocked, 1'b1);
        i2c_master_model_i.xfer(8'h5a, 1'b1, r, nak);
        chk1("abort", nak, 1'b1);
        i2c_master_model_i.start_c();
        i2c_master_model_i.xfer({DEV, 1'b0}, 1'b1, r, nak);
        chk1("refused", nak, 1'b1);
        i2c_master_model_i.stop_c();
        repeat (66000) @(posedge clk_sys_i);
        pf <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk1("open", blocked, 1'b0);
        get(6'h00, 7, 1'b0);
        same('{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h01});
        get(6'h08, 1, 1'b1);
        same('{8'h11});
    endtask : s_power

    initial begin
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        s_reset();
        s_burst();
        s_wrap();
        s_square();
        s_power();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
